// File: sfe_defines.svh
/*
 * Offsets, field positions, reset values and fixed encodings of the
 * floating-point exception unit.
 * Assumes: included by bare name from the unit.
 */
`ifndef SFE_DEFINES_SVH
`define SFE_DEFINES_SVH

// ****************************************************************
// Register byte offsets
// ****************************************************************
`define SFE_OFF_CSR 8'h00
`define SFE_OFF_CR4 8'h04
`define SFE_OFF_LAST 8'h08

// ****************************************************************
// Control/status fields
// ****************************************************************
`define SFE_FLAG_LO 0
`define SFE_MASK_LO 7
`define SFE_NUM_EXC 6
`define SFE_DAZ_BIT 6
`define SFE_FTZ_BIT 15
`define SFE_CSR_WMASK 32'h0000FFFF
`define SFE_CSR_RST 32'h00001F80
`define SFE_OS_SUPPORT_BIT 10

// ****************************************************************
// Special values
// ****************************************************************
`define SFE_QBIT_S 32'h00400000
`define SFE_QBIT_D 64'h0008000000000000
`define SFE_INDEF_S 64'h00000000FFC00000
`define SFE_INDEF_D 64'hFFF8000000000000
`define SFE_INT_INDEF_32 64'h0000000080000000
`define SFE_INT_INDEF_64 64'h8000000000000000
`define SFE_ONES_S 64'h00000000FFFFFFFF
`define SFE_ONES_D 64'hFFFFFFFFFFFFFFFF
`define SFE_UNORD_FLAGS 3'h7
`define SFE_EXP_S_I32 8'h9E
`define SFE_EXP_S_I64 8'hBE
`define SFE_EXP_D_I32 11'h41E
`define SFE_EXP_D_I64 11'h43E

`endif

// File: sfe_pkg.sv
/*
 * Types shared by the floating-point exception unit.
 * Assumes: sfe_defines.svh on the include path.
 */
package sfe_pkg;

    // Operation class presented by the datapath
    typedef enum logic [3:0] {
        OP_ADD = 4'h0,
        OP_SUB = 4'h1,
        OP_MUL = 4'h2,
        OP_DIV = 4'h3,
        OP_SQRT = 4'h4,
        OP_MAXMIN = 4'h5,
        OP_CMPMASK = 4'h6,
        OP_CVTFP = 4'h7,
        OP_ORDCMP = 4'h8,
        OP_UNORDCMP = 4'h9,
        OP_CVTINT = 4'hA,
        OP_LEGACY_TRUNC = 4'hB,
        OP_OTHER = 4'hC
    } sfe_op_e;

    // Compare-to-mask predicates
    typedef enum logic [2:0] {
        PR_EQ = 3'h0,
        PR_LT = 3'h1,
        PR_LE = 3'h2,
        PR_UNORD = 3'h3,
        PR_NEQ = 3'h4,
        PR_NLT = 3'h5,
        PR_NLE = 3'h6,
        PR_ORD = 3'h7
    } sfe_pred_e;

    // Operand classification
    typedef struct packed {
        logic nan;
        logic snan;
        logic inf;
        logic zero;
        logic neg;
    } sfe_class_s;

endpackage : sfe_pkg

// File: sfe_exception_unit.sv
/*
 * Floating-point exception unit for packed and scalar SIMD operations:
 * one lane of invalid-operation detection and masked response, sticky
 * flags, masks, and the fault dispatch gate, plus an AHB-Lite slave.
 * Assumes: one lane per request (a packed op is presented lane by
 * lane, flags OR together); the datapath reports the other five
 * exception conditions itself; inputs synchronous to ref_clk.
 */
// The placing of the registers and register access over AHB-Lite were chosen for this implementation.
`timescale 1ns/100ps
`include "sfe_defines.svh"

module sfe_exception_unit
(
    input wire logic ref_clk,
    input wire logic sys_rst,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [7:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic [31:0] hrdata,
    output logic hresp,
    // Datapath request
    input wire logic opValid,
    input wire logic [3:0] opCode,
    input wire logic [2:0] opPred,
    input wire logic opDouble,
    input wire logic opInt64,
    input wire logic [63:0] srcA,
    input wire logic [63:0] srcB,
    input wire logic [63:0] resultIn,
    input wire logic [2:0] cmpFlagsIn,
    input wire logic [4:0] postExcIn,
    // Response to datapath and dispatch
    output logic [63:0] resultOut,
    output logic destWrite,
    output logic [2:0] statusFlagsOut,
    output logic flagsWrite,
    output logic simdFpFault,
    output logic invalidOpcodeFault
);

    // ************************************************************
    // Helper functions
    // ************************************************************

    // Classify an operand of either precision
    function automatic sfe_pkg::sfe_class_s fpClass(
        input logic [63:0] v,
        input logic dbl
    );
        sfe_pkg::sfe_class_s c;
        logic expMax;
        logic expZero;
        logic manZero;
        logic qBit;
        expMax = dbl ? (&v[62:52]) : (&v[30:23]);
        expZero = dbl ? ~(|v[62:52]) : ~(|v[30:23]);
        manZero = dbl ? ~(|v[51:0]) : ~(|v[22:0]);
        qBit = dbl ? v[51] : v[22];
        c.nan = expMax & ~manZero;
        c.snan = expMax & ~manZero & ~qBit;
        c.inf = expMax & manZero;
        c.zero = expZero & manZero;
        c.neg = dbl ? v[63] : v[31];
        return c;
    endfunction : fpClass

    // Turn a signalling NaN into its quiet form
    function automatic logic [63:0] quieten(
        input logic [63:0] v,
        input logic dbl
    );
        logic [63:0] q;
        if (dbl)
        begin
            q = v | `SFE_QBIT_D;
        end
        else
        begin
            q = {32'h00000000, v[31:0] | `SFE_QBIT_S};
        end
        return q;
    endfunction : quieten

    // ************************************************************
    // Register state
    // ************************************************************
    logic [31:0] csr_r;
    logic [31:0] csr_nxt;
    logic osSupport_r;
    logic [7:0] lastExc_r;
    logic wrPend_r;
    logic [7:0] wrAddr_r;

    logic [`SFE_NUM_EXC-1:0] flags;
    logic [`SFE_NUM_EXC-1:0] masks;
    logic [`SFE_NUM_EXC-1:0] excSet;
    logic csrWrite;
    logic cr4Write;
    logic addrPhase;

    assign flags = csr_r[`SFE_FLAG_LO +: `SFE_NUM_EXC];
    assign masks = csr_r[`SFE_MASK_LO +: `SFE_NUM_EXC];
    assign addrPhase = hsel & htrans[1] & hready;
    assign csrWrite = wrPend_r & (wrAddr_r == `SFE_OFF_CSR);
    assign cr4Write = wrPend_r & (wrAddr_r == `SFE_OFF_CR4);

    // ************************************************************
    // Invalid-operation detection and masked response
    // ************************************************************
    sfe_pkg::sfe_class_s ca;
    sfe_pkg::sfe_class_s cb;
    logic invDet;
    logic anyNan;
    logic anySnan;
    logic negPred;
    logic qnanPred;
    logic rangeOut;
    logic [63:0] maskedVal;
    logic [63:0] indef;
    logic [63:0] nanPick;
    logic hasValue;

    // Mode bits unused: detection is mode-free
    always_comb
    begin
        ca = fpClass(srcA, opDouble);
        cb = fpClass(srcB, opDouble);
        anyNan = ca.nan | cb.nan;
        anySnan = ca.snan | cb.snan;
        indef = opDouble ? `SFE_INDEF_D : `SFE_INDEF_S;
        nanPick = quieten(ca.nan ? srcA : srcB, opDouble);
        negPred = (opPred == sfe_pkg::PR_NEQ) |
                  (opPred == sfe_pkg::PR_UNORD) |
                  (opPred == sfe_pkg::PR_NLT) |
                  (opPred == sfe_pkg::PR_NLE);
        qnanPred = (opPred == sfe_pkg::PR_LT) |
                   (opPred == sfe_pkg::PR_LE) |
                   (opPred == sfe_pkg::PR_NLT) |
                   (opPred == sfe_pkg::PR_NLE);
        if (opDouble)
        begin
            rangeOut = srcA[62:52] >= (opInt64 ? `SFE_EXP_D_I64
                                               : `SFE_EXP_D_I32);
        end
        else
        begin
            rangeOut = srcA[30:23] >= (opInt64 ? `SFE_EXP_S_I64
                                               : `SFE_EXP_S_I32);
        end
        invDet = 1'b0;
        hasValue = 1'b1;
        maskedVal = resultIn;
        unique case (opCode)
            sfe_pkg::OP_ADD, sfe_pkg::OP_SUB:
            begin
                // Effective subtraction of infinities is invalid
                if (anySnan)
                begin
                    invDet = 1'b1;
                    maskedVal = nanPick;
                end
                else if (ca.inf & cb.inf &
                         ((ca.neg ^ cb.neg) ^
                          (opCode == sfe_pkg::OP_SUB)))
                begin
                    invDet = 1'b1;
                    maskedVal = indef;
                end
            end
            sfe_pkg::OP_MUL:
            begin
                if (anySnan)
                begin
                    invDet = 1'b1;
                    maskedVal = nanPick;
                end
                else if ((ca.inf & cb.zero) | (ca.zero & cb.inf))
                begin
                    invDet = 1'b1;
                    maskedVal = indef;
                end
            end
            sfe_pkg::OP_DIV:
            begin
                if (anySnan)
                begin
                    invDet = 1'b1;
                    maskedVal = nanPick;
                end
                else if ((ca.zero & cb.zero) | (ca.inf & cb.inf))
                begin
                    invDet = 1'b1;
                    maskedVal = indef;
                end
            end
            sfe_pkg::OP_SQRT:
            begin
                // Operand of a square root travels in srcB
                if (cb.snan)
                begin
                    invDet = 1'b1;
                    maskedVal = quieten(srcB, opDouble);
                end
                else if (cb.neg & ~cb.zero & ~cb.nan)
                begin
                    invDet = 1'b1;
                    maskedVal = indef;
                end
            end
            sfe_pkg::OP_MAXMIN:
            begin
                if (anyNan)
                begin
                    invDet = 1'b1;
                    maskedVal = srcB;
                end
            end
            sfe_pkg::OP_CMPMASK:
            begin
                invDet = anySnan | (anyNan & qnanPred);
                if (anyNan)
                begin
                    // Mask is produced even when nothing is invalid
                    maskedVal = negPred ? (opDouble ? `SFE_ONES_D
                                                    : `SFE_ONES_S)
                                        : 64'h0000000000000000;
                end
            end
            sfe_pkg::OP_CVTFP:
            begin
                if (ca.snan)
                begin
                    invDet = 1'b1;
                    maskedVal = quieten(srcA, opDouble);
                end
            end
            sfe_pkg::OP_ORDCMP:
            begin
                hasValue = 1'b0;
                invDet = anyNan;
            end
            sfe_pkg::OP_UNORDCMP:
            begin
                hasValue = 1'b0;
                invDet = anySnan;
            end
            sfe_pkg::OP_CVTINT:
            begin
                if (ca.nan | ca.inf | rangeOut)
                begin
                    invDet = 1'b1;
                    maskedVal = opInt64 ? `SFE_INT_INDEF_64
                                        : `SFE_INT_INDEF_32;
                end
            end
            sfe_pkg::OP_LEGACY_TRUNC:
            begin
                invDet = 1'b0;
            end
            default:
            begin
                invDet = anySnan;
                if (anySnan)
                begin
                    maskedVal = nanPick;
                end
            end
        endcase
    end

    // ************************************************************
    // Exception gathering and fault gate
    // ************************************************************
    logic legacyOp;
    logic unmaskedHit;
    logic preUnmasked;

    // New conditions; legacy op is exempt
    always_comb
    begin
        legacyOp = opCode == sfe_pkg::OP_LEGACY_TRUNC;
        excSet = '0;
        if (opValid & ~legacyOp)
        begin
            excSet[0] = invDet;
            excSet[1] = postExcIn[0];
            excSet[2] = postExcIn[1];
            excSet[3] = postExcIn[2];
            excSet[4] = postExcIn[3];
            excSet[5] = postExcIn[4];
        end
        unmaskedHit = |(excSet & ~masks);
        // Pre-computation classes stop the destination write
        preUnmasked = |(excSet[2:0] & ~masks[2:0]);
    end

    // Software write replaces; a hardware set wins
    always_comb
    begin
        if (csrWrite)
        begin
            csr_nxt = hwdata & `SFE_CSR_WMASK;
        end
        else
        begin
            csr_nxt = csr_r;
        end
        csr_nxt[`SFE_FLAG_LO +: `SFE_NUM_EXC] =
            csr_nxt[`SFE_FLAG_LO +: `SFE_NUM_EXC] | excSet;
    end

    // ************************************************************
    // Control/status and OS-support registers
    // ************************************************************
    always_ff @(posedge ref_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            csr_r <= `SFE_CSR_RST;
        end
        else
        begin
            csr_r <= csr_nxt;
        end
    end

    // OS support bit
    always_ff @(posedge ref_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            osSupport_r <= 1'b0;
        end
        else if (cr4Write)
        begin
            osSupport_r <= hwdata[`SFE_OS_SUPPORT_BIT];
        end
    end

    // Last operation's conditions
    always_ff @(posedge ref_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            lastExc_r <= 8'h00;
        end
        else if (opValid)
        begin
            lastExc_r <= {unmaskedHit & ~osSupport_r,
                          unmaskedHit & osSupport_r, 
                          excSet};
        end
    end

    // ************************************************************
    // Datapath response, one cycle after completion
    // ************************************************************
    always_ff @(posedge ref_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            resultOut <= 64'h0000000000000000;
            destWrite <= 1'b0;
            statusFlagsOut <= 3'h0;
            flagsWrite <= 1'b0;
        end
        else
        begin
            // Unmasked invalid leaves destination untouched
            resultOut <= (invDet & ~masks[0]) ? resultIn
                                              : maskedVal;
            destWrite <= opValid & hasValue &
                         (legacyOp | ~preUnmasked);
            statusFlagsOut <= anyNan ? `SFE_UNORD_FLAGS
                                     : cmpFlagsIn;
            flagsWrite <= opValid & ~hasValue & ~preUnmasked;
        end
    end

    // Fault pulses, precise to the completing operation
    always_ff @(posedge ref_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            simdFpFault <= 1'b0;
            invalidOpcodeFault <= 1'b0;
        end
        else
        begin
            simdFpFault <= unmaskedHit & osSupport_r;
            invalidOpcodeFault <= unmaskedHit & ~osSupport_r;
        end
    end

    // ************************************************************
    // AHB-Lite slave
    // ************************************************************
    // Write address held for the data phase
    always_ff @(posedge ref_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            wrPend_r <= 1'b0;
            wrAddr_r <= 8'h00;
        end
        else
        begin
            wrPend_r <= addrPhase & hwrite & (hsize == 3'h2);
            wrAddr_r <= haddr;
        end
    end

    // CSR and CR4 read data taken from next values so a read after write sees it
    always_ff @(posedge ref_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            hrdata <= 32'h00000000;
        end
        else if (addrPhase & ~hwrite)
        begin
            unique case (haddr)
                `SFE_OFF_CSR:
                begin
                    hrdata <= csr_nxt;
                end
                `SFE_OFF_CR4:
                begin
                    hrdata <= 32'(cr4Write ? hwdata[`SFE_OS_SUPPORT_BIT]
                                           : osSupport_r)
                              << `SFE_OS_SUPPORT_BIT;
                end
                `SFE_OFF_LAST:
                begin
                    hrdata <= {24'h000000, lastExc_r};
                end
                default:
                begin
                    hrdata <= 32'h00000000;
                end
            endcase
        end
    end

    // Zero wait states, always OKAY
    always_ff @(posedge ref_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end
        else
        begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end
    end

endmodule : sfe_exception_unit

// File: sfe_exception_unit_monitor.sv
/*
 * Port checks for the exception unit.
 * Assumes: bound to sfe_exception_unit; one clock, async reset high.
 */
`timescale 1ns/100ps

module sfe_exception_unit_monitor
(
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic hsel,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic hready,
    input wire logic hreadyout,
    input wire logic [31:0] hrdata,
    input wire logic hresp,
    input wire logic opValid,
    input wire logic [3:0] opCode,
    input wire logic [2:0] cmpFlagsIn,
    input wire logic destWrite,
    input wire logic [2:0] statusFlagsOut,
    input wire logic flagsWrite,
    input wire logic simdFpFault,
    input wire logic invalidOpcodeFault
);
    default clocking mc @(posedge ref_clk);
    endclocking
    default disable iff (sys_rst);

    // Decoded causes
    logic rdTaken;
    logic cmpOp;
    assign rdTaken = hsel && htrans[1] && hready && !hwrite;
    assign cmpOp = opValid && (opCode == sfe_pkg::OP_ORDCMP
        || opCode == sfe_pkg::OP_UNORDCMP);

    // ****************************************************************
    // Properties
    // ****************************************************************
    property p_bus_ok;
        hreadyout && !hresp;
    endproperty
    a_bus_ok: assert property (p_bus_ok)
        else $error("bus answer not OKAY");
    property p_rdata_hold;
        !$past(rdTaken) |-> $stable(hrdata);
    endproperty
    a_rdata_hold: assert property (p_rdata_hold)
        else $error("read data moved");
    property p_idle_quiet;
        !$past(opValid) |-> !(destWrite || flagsWrite || simdFpFault
            || invalidOpcodeFault);
    endproperty
    a_idle_quiet: assert property (p_idle_quiet)
        else $error("response without operation");
    property p_fault_excl;
        !(simdFpFault && invalidOpcodeFault);
    endproperty
    a_fault_excl: assert property (p_fault_excl)
        else $error("both faults");
    property p_legacy;
        $past(opValid && opCode == sfe_pkg::OP_LEGACY_TRUNC)
            |-> !simdFpFault && !invalidOpcodeFault;
    endproperty
    a_legacy: assert property (p_legacy)
        else $error("legacy fault");
    property p_cmp_writes;
        $past(cmpOp) && !simdFpFault && !invalidOpcodeFault |-> flagsWrite;
    endproperty
    a_cmp_writes: assert property (p_cmp_writes)
        else $error("compare wrote no flags");
    property p_flags_cause;
        flagsWrite |-> $past(cmpOp);
    endproperty
    a_flags_cause: assert property (p_flags_cause)
        else $error("flags without compare");
    property p_flags_value;
        flagsWrite |-> statusFlagsOut == 3'h7
            || statusFlagsOut == $past(cmpFlagsIn);
    endproperty
    a_flags_value: assert property (p_flags_value)
        else $error("bad status flags");

    // Main scenarios reached
    c_simd: cover property (simdFpFault);
    c_undef: cover property (invalidOpcodeFault);
    c_flags: cover property (flagsWrite && statusFlagsOut == 3'h7);
endmodule : sfe_exception_unit_monitor

// File: sfe_dp_model.sv
/*
 * Datapath model: one lane a request, a fixed unmasked result.
 * Assumes: issue is called just after a rising clock edge.
 */
`timescale 1ns/100ps

module sfe_dp_model
#(
    parameter logic [63:0] RES = 64'h4000000000000000
)
(
    input wire logic clk,
    output logic opValid,
    output logic [3:0] opCode,
    output logic [2:0] opPred,
    output logic opDouble,
    output logic opInt64,
    output logic [63:0] srcA,
    output logic [63:0] srcB,
    output logic [63:0] resultIn,
    output logic [2:0] cmpFlagsIn,
    output logic [4:0] postExcIn
);
    // Idle request lines from time zero
    initial
    begin
        opValid = 1'b0;
        opCode = 4'h0;
        opPred = 3'h0;
        opDouble = 1'b1;
        opInt64 = 1'b0;
        srcA = 64'h0;
        srcB = 64'h0;
        resultIn = RES;
        cmpFlagsIn = 3'h2;
        postExcIn = 5'h00;
    end

    // One lane completes in one cycle
    task automatic issue(input logic [3:0] c, input logic [2:0] p,
        input logic [63:0] a, input logic [63:0] b, input logic [4:0] x);
        opValid <= 1'b1;
        opCode <= c;
        opPred <= p;
        srcA <= a;
        srcB <= b;
        postExcIn <= x;
        @(posedge clk);
        // Released operands show garbage, never the old value
        opValid <= 1'b0;
        srcA <= ~a;
        srcB <= ~b;
        postExcIn <= 5'h00;
    endtask : issue
endmodule : sfe_dp_model

// File: sfe_exception_unit_tb.sv
/*
 * Self-checking bench for the exception unit.
 * Assumes: unit, datapath model and monitor compiled first.
 */
`timescale 1ns/100ps

module sfe_exception_unit_tb;
    localparam logic [63:0] SN = 64'h7FF0000000000001;
    localparam logic [63:0] SQ = 64'h7FF8000000000001;
    localparam logic [63:0] QN = 64'h7FF8000000000000;
    localparam logic [63:0] ONE = 64'h3FF0000000000000;
    localparam logic [63:0] INF = 64'h7FF0000000000000;
    localparam logic [63:0] IND = 64'hFFF8000000000000;
    logic refClk = 1'b0;
    logic sysRst = 1'b1;
    logic hsel = 1'b0;
    logic [7:0] haddr = 8'h00;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] hrdata, rdq;
    logic hreadyout, hresp, destWrite, flagsWrite;
    logic simdFpFault, invalidOpcodeFault, opValid, opDouble, opInt64;
    logic [3:0] opCode;
    logic [2:0] opPred, cmpFlagsIn, statusFlagsOut;
    logic [63:0] srcA, srcB, resultIn, resultOut;
    logic [4:0] postExcIn;
    int mismatches = 0;
    int numChecks = 0;

    // Clock, 40 ns period
    always #20 refClk = ~refClk;

    sfe_dp_model dp (.clk(refClk), .opValid, .opCode, .opPred, .opDouble,
        .opInt64, .srcA, .srcB, .resultIn, .cmpFlagsIn, .postExcIn);
    sfe_exception_unit uut (.ref_clk(refClk), .sys_rst(sysRst), .hsel,
        .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready(hreadyout),
        .hreadyout, .hrdata, .hresp, .opValid, .opCode, .opPred,
        .opDouble, .opInt64, .srcA, .srcB, .resultIn, .cmpFlagsIn,
        .postExcIn, .resultOut, .destWrite, .statusFlagsOut, .flagsWrite,
        .simdFpFault, .invalidOpcodeFault);

    // ****************************************************************
    // Shared tasks
    // ****************************************************************
    task automatic chk(input string n, input logic [63:0] e,
        input logic [63:0] g);
        numChecks++;
        if (g !== e)
        begin
            mismatches++;
            $display("Error %s expected %h seen %h", n, e, g);
        end
    endtask : chk

    // One word transfer; read data lands in rdq
    task automatic bus(input logic w, input logic [7:0] a,
        input logic [31:0] d);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= a;
        hwrite <= w;
        do @(posedge refClk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge refClk); while (hreadyout !== 1'b1);
        rdq = hrdata;
    endtask : bus

    task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        chk("register", {32'h0, e}, {32'h0, rdq});
    endtask : rdchk

    // ev is {flagsWrite, destWrite, simdFpFault, invalidOpcodeFault}
    task automatic run(input logic [3:0] c, input logic [2:0] p,
        input logic [63:0] a, b, e, input logic [3:0] ev);
        dp.issue(c, p, a, b, 5'h00);
        @(negedge refClk);
        chk("response", {60'h0, ev},
            {60'h0, flagsWrite, destWrite, simdFpFault, invalidOpcodeFault});
        if (ev[2])
            chk("result", e, resultOut);
        if (ev[3])
            chk("status", 64'h7, {61'h0, statusFlagsOut});
        @(posedge refClk);
    endtask : run

    // ****************************************************************
    // Scenarios
    // ****************************************************************
    task automatic t_reset;
        rdchk(8'h00, 32'h00001F80);
        rdchk(8'h04, 32'h0);
        rdchk(8'h0C, 32'h0);
        $display("test reset done");
    endtask : t_reset

    // Masked responses
    task automatic t_masked;
        run(sfe_pkg::OP_ADD, 3'h0, SN, ONE, SQ, 4'h4);
        run(sfe_pkg::OP_SQRT, 3'h0, ONE, ~ONE, IND, 4'h4);
        run(sfe_pkg::OP_MAXMIN, 3'h0, QN, ONE, ONE, 4'h4);
        run(sfe_pkg::OP_CVTFP, 3'h0, SN, ONE, SQ, 4'h4);
        run(sfe_pkg::OP_ADD, 3'h0, INF, {1'b1, INF[62:0]}, IND,
            4'h4);
        run(sfe_pkg::OP_MUL, 3'h0, INF, 64'h0, IND, 4'h4);
        run(sfe_pkg::OP_DIV, 3'h0, 64'h0, 64'h0, IND, 4'h4);
        run(sfe_pkg::OP_CVTINT, 3'h0, INF, ONE, 64'h80000000,
            4'h4);
        for (int p = 0; p < 8; p++)
            run(sfe_pkg::OP_CMPMASK, p[2:0], QN, ONE,
                {64{p >= 3 && p <= 6}}, 4'h4);
        rdchk(8'h00, 32'h00001F81);
        $display("test masked done");
    endtask : t_masked

    // Quiet NaN cases
    task automatic t_quiet;
        bus(1'b1, 8'h00, 32'h00001F80);
        run(sfe_pkg::OP_ADD, 3'h0, QN, ONE, dp.RES, 4'h4);
        run(sfe_pkg::OP_CMPMASK, 3'h0, QN, ONE, 64'h0, 4'h4);
        rdchk(8'h00, 32'h00001F80);
        run(sfe_pkg::OP_ORDCMP, 3'h0, QN, ONE, 64'h0, 4'h8);
        rdchk(8'h00, 32'h00001F81);
        $display("test quiet done");
    endtask : t_quiet

    // Unmasked invalid through both gate settings
    task automatic t_fault;
        bus(1'b1, 8'h00, 32'h00001F00);
        dp.issue(sfe_pkg::OP_LEGACY_TRUNC, 3'h0, SN, ONE, 5'h00);
        @(negedge refClk);
        chk("legacy", 64'h0,
            {62'h0, simdFpFault, invalidOpcodeFault});
        @(posedge refClk);
        rdchk(8'h00, 32'h00001F00);
        run(sfe_pkg::OP_ADD, 3'h0, SN, ONE, 64'h0, 4'h1);
        rdchk(8'h08, 32'h00000081);
        bus(1'b1, 8'h04, 32'h00000400);
        rdchk(8'h04, 32'h00000400);
        run(sfe_pkg::OP_ADD, 3'h0, SN, ONE, 64'h0, 4'h2);
        bus(1'b1, 8'h04, 32'h0);
        $display("test fault done");
    endtask : t_fault

    // Modes leave invalid alone
    task automatic t_modes;
        bus(1'b1, 8'h00, 32'h00009FC0);
        run(sfe_pkg::OP_ADD, 3'h0, SN, ONE, SQ, 4'h4);
        rdchk(8'h00, 32'h00009FC1);
        $display("test modes done");
    endtask : t_modes

    // Post-computation flags
    task automatic t_post;
        bus(1'b1, 8'h00, 32'h00001F80);
        dp.issue(sfe_pkg::OP_ADD, 3'h0, ONE, ONE, 5'h1F);
        rdchk(8'h00, 32'h00001FBE);
        dp.issue(sfe_pkg::OP_ADD, 3'h0, ONE, ONE, 5'h00);
        rdchk(8'h00, 32'h00001FBE);
        bus(1'b1, 8'h00, 32'h0);
        rdchk(8'h00, 32'h0);
        $display("test post done");
    endtask : t_post

    task automatic conclude;
        $display("checks %0d mismatches %0d", numChecks, mismatches);
        if (mismatches == 0 && numChecks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : conclude

    // Tasks start just after a rising edge
    initial
    begin
        repeat (8) @(posedge refClk);
        sysRst <= 1'b0;
        @(posedge refClk);
        t_reset();
        t_masked();
        t_quiet();
        t_fault();
        t_modes();
        t_post();
        conclude();
    end

    // Watchdog, well past the run
    initial
    begin
        #(40 * 5000);
        mismatches++;
        conclude();
    end
endmodule : sfe_exception_unit_tb

bind sfe_exception_unit sfe_exception_unit_monitor mon (.ref_clk,
    .sys_rst, .hsel, .htrans, .hwrite, .hready, .hreadyout, .hrdata,
    .hresp, .opValid, .opCode, .cmpFlagsIn, .destWrite, .statusFlagsOut,
    .flagsWrite, .simdFpFault, .invalidOpcodeFault);
